// ---- core/power_mgmt_capability_word.sv ----
// Contract
// - word lives at offset A2h of function 0, reads FE12h after reset
// - bit 15 cold-state wake is writable, defaults to 1, reads back last write
// - bits 14 to 11 read as ones
// - bit 10 reads 1, state two supported
// - bit 9 reads 1, state one supported
// - bits 8 to 6 read zero, writes ignored
// - bit 5 reads 0, no special initialization needed
// - bit 4 set means system supplies auxiliary power for cold wake
// - bit 4 reads 0 whenever bit 15 is 0
// - bit 3 tells if wake needs bus clock, 0 when no wake state
// - bits 2 to 0 read 010b, capability version
// - bit 15 restored only by power-on reset or global reset, not by bus reset
`default_nettype none
module power_mgmt_capability_word
  import pm_cap_pkg::*;
(
  input wire logic clk, // system clock, 10 MHz
  input wire logic nrst, // async power-on reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic global_reset_n, // global reset pin, active low
  input wire logic bus_reset_n, // bus reset pin, active low
  input wire logic cfg_req, // config access request, one-cycle pulse
  input wire logic cfg_write, // 1 write, 0 read
  input wire logic [2:0] cfg_func, // function number
  input wire logic [7:0] cfg_addr, // dword-aligned config byte address
  input wire logic [3:0] cfg_byte_en, // byte enables, active high
  input wire logic [31:0] cfg_wdata, // write data
  output logic cfg_ack, // answer pulse
  output logic cfg_hit, // access claimed by this word
  output logic [31:0] cfg_rdata, // read data, word in lanes 3:2
  output logic cold_wake_enabled, // bit 15 as held
  output logic aux_supply_flag // bit 4 as read
);
  logic global_reset_n_level;
  logic brst_level;
  logic cold_wake;
  logic [15:0] cap_word;
  logic addr_match;
  logic lanes_touched;
  logic bit15_wr;
  logic [3:0] wake_state_mask;
  logic state_two_supported;
  logic state_one_supported;
  logic wake_needs_bus_clock;

  pin_sync u_global_reset_n_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .pin(global_reset_n),
    .level(global_reset_n_level)
  );

  pin_sync u_brst_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .pin(bus_reset_n),
    .level(brst_level)
  );

  // decode: only function 0, the dword holding A2h, and a lane of the word enabled
  assign addr_match = (cfg_func == PM_CAP_FUNC) && (cfg_addr[7:2] == PM_CAP_DWORD);
  assign lanes_touched = |cfg_byte_en[3:2];

  // only bit 15 has storage; every other write lane bit is dropped
  // a request refused during bus reset must not write bit 15 behind an unanswered access
  assign bit15_wr = cfg_req && cfg_write && addr_match && cfg_byte_en[3] && brst_level;

  cold_wake_bit u_cold_wake (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .restore(!global_reset_n_level),
    .wr(bit15_wr),
    .wdata(cfg_wdata[16 + COLD_WAKE_BIT]),
    .value(cold_wake)
  );

  assign wake_state_mask = WAKE_HI_VAL;
  assign state_two_supported = STATE_TWO_VAL;
  assign state_one_supported = STATE_ONE_VAL;
  // wake is always supported from the hot states, so the clock bit reflects the real need
  assign wake_needs_bus_clock = CLK_NEEDED & ((|wake_state_mask) | cold_wake);

  always_comb
  begin
    cap_word = 16'h0000;
    cap_word[COLD_WAKE_BIT] = cold_wake;
    cap_word[WAKE_HI_MSB:WAKE_HI_LSB] = wake_state_mask;
    cap_word[STATE_TWO_BIT] = state_two_supported;
    cap_word[STATE_ONE_BIT] = state_one_supported;
    cap_word[RSVD_MSB:RSVD_LSB] = RSVD_VAL;
    cap_word[INIT_BIT] = INIT_VAL;
    cap_word[AUX_BIT] = AUX_FROM_SYSTEM & cold_wake;
    cap_word[CLK_BIT] = wake_needs_bus_clock;
    cap_word[VER_MSB:VER_LSB] = VER_VAL;
  end

  // answer one cycle after the request; bus reset drops a pending answer but not bit 15
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_ack <= 1'b0;
      cfg_hit <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (!brst_level)
      begin
        cfg_ack <= 1'b0;
        cfg_hit <= 1'b0;
        cfg_rdata <= 32'h0000_0000;
      end
      else
      begin
        cfg_ack <= cfg_req;
        cfg_hit <= cfg_req && addr_match && lanes_touched;
        if (cfg_req && !cfg_write && addr_match && lanes_touched)
        begin
          cfg_rdata <= 32'h0000_0000;
          if (cfg_byte_en[2])
            cfg_rdata[23:16] <= cap_word[7:0];
          if (cfg_byte_en[3])
            cfg_rdata[31:24] <= cap_word[15:8];
        end
        else if (cfg_req)
          cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  // status copies so the outputs come from flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cold_wake_enabled <= COLD_WAKE_RESET;
      aux_supply_flag <= AUX_FROM_SYSTEM;
    end
    else if (ce)
    begin
      cold_wake_enabled <= cold_wake;
      aux_supply_flag <= cap_word[AUX_BIT];
    end
  end
endmodule
`default_nettype wire

// ---- core/pm_cap_pkg.sv ----
`default_nettype none
package pm_cap_pkg;
  // configuration space location of the capability word
  localparam logic [2:0] PM_CAP_FUNC = 3'h0;
  localparam logic [7:0] PM_CAP_OFFSET = 8'hA2;
  localparam logic [5:0] PM_CAP_DWORD = PM_CAP_OFFSET[7:2];
  localparam int PM_CAP_LANE_LO = 2;
  localparam logic [15:0] PM_CAP_RESET = 16'hFE12;

  // field positions
  localparam int COLD_WAKE_BIT = 15;
  localparam int WAKE_HI_MSB = 14;
  localparam int WAKE_HI_LSB = 11;
  localparam int STATE_TWO_BIT = 10;
  localparam int STATE_ONE_BIT = 9;
  localparam int RSVD_MSB = 8;
  localparam int RSVD_LSB = 6;
  localparam int INIT_BIT = 5;
  localparam int AUX_BIT = 4;
  localparam int CLK_BIT = 3;
  localparam int VER_MSB = 2;
  localparam int VER_LSB = 0;

  // field values, fixed except the bit 15 reset value
  localparam logic COLD_WAKE_RESET = 1'b1;
  localparam logic [3:0] WAKE_HI_VAL = 4'hF;
  localparam logic STATE_TWO_VAL = 1'b1;
  localparam logic STATE_ONE_VAL = 1'b1;
  localparam logic [2:0] RSVD_VAL = 3'h0;
  localparam logic INIT_VAL = 1'b0;
  localparam logic AUX_FROM_SYSTEM = 1'b1;
  localparam logic CLK_NEEDED = 1'b0;
  localparam logic [2:0] VER_VAL = 3'h2;

  // config access answers one cycle after the request
  localparam int CFG_ANSWER_CYCLES = 1;
endpackage
`default_nettype wire

// ---- core/pin_sync.sv ----
`default_nettype none
module pin_sync
  import pm_cap_pkg::*;
#(
  parameter logic IDLE = 1'b1
)
(
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic pin, // raw pin level
  output logic level // filtered level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
    end
    else if (ce)
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change is taken only once the last two stages agree
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      level <= IDLE;
    else if (ce && (s2 == s3))
      level <= s3;
  end
endmodule
`default_nettype wire

// ---- core/cold_wake_bit.sv ----
`default_nettype none
module cold_wake_bit
  import pm_cap_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic restore, // filtered global reset asserted
  input wire logic wr, // write strobe for this bit
  input wire logic wdata, // value written
  output logic value // current bit value
);
  // the bus reset is deliberately not an input here: only the power-on reset and the global reset restore it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      value <= COLD_WAKE_RESET;
    else if (ce)
    begin
      if (restore)
        value <= COLD_WAKE_RESET;
      else if (wr)
        value <= wdata;
    end
  end
endmodule
`default_nettype wire

// ---- sim/pm_cap_monitor.sv ----
`default_nettype none
module pm_cap_monitor
  import pm_cap_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic ce, // enable
  input wire logic global_reset_n, // global pin
  input wire logic bus_reset_n, // bus pin
  input wire logic cfg_req, // request
  input wire logic cfg_write, // write
  input wire logic [2:0] cfg_func, // function
  input wire logic [7:0] cfg_addr, // address
  input wire logic [3:0] cfg_byte_en, // lanes
  input wire logic [31:0] cfg_wdata, // wdata
  input wire logic cfg_ack, // answer
  input wire logic cfg_hit, // claimed
  input wire logic [31:0] cfg_rdata, // rdata
  input wire logic cold_wake_enabled, // bit 15
  input wire logic aux_supply_flag // bit 4
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // pins pass a synchroniser, so they must have been quiet for a few edges
  sequence s_req; cfg_req && ce && bus_reset_n && $past(bus_reset_n, 5); endsequence
  sequence s_mine; s_req ##0 cfg_func == PM_CAP_FUNC && cfg_addr[7:2] == PM_CAP_DWORD; endsequence
  sequence s_rd; s_mine ##0 !cfg_write && cfg_byte_en[3:2] == 2'b11; endsequence
  property p_ack; s_req |=> cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("answer missing");
  property p_other; s_req ##0 cfg_func != PM_CAP_FUNC |=> !cfg_hit && cfg_rdata == 32'h0000_0000; endproperty
  a_other: assert property (p_other) else $error("foreign access claimed");
  property p_hi; s_rd |=> cfg_hit && cfg_rdata[30:25] == 6'h3F; endproperty
  a_hi: assert property (p_hi) else $error("wake or state bits wrong");
  property p_lo; s_rd |=> cfg_rdata[24:21] == 4'h0 && cfg_rdata[19:16] == 4'h2; endproperty
  a_lo: assert property (p_lo) else $error("fixed low bits wrong");
  property p_auxbit; s_rd |=> cfg_rdata[20] == cfg_rdata[31]; endproperty
  a_auxbit: assert property (p_auxbit) else $error("aux bit not tied to bit 15");
  property p_auxflag; aux_supply_flag == cold_wake_enabled; endproperty
  a_auxflag: assert property (p_auxflag) else $error("aux flag mismatch");
  property p_write; s_mine ##0 cfg_write && cfg_byte_en[3] && global_reset_n && $past(global_reset_n, 5)
    |=> ##1 cold_wake_enabled == $past(cfg_wdata[31], 2); endproperty
  a_write: assert property (p_write) else $error("bit 15 not written");
  property p_global_reset_n; !global_reset_n [*8] |=> cold_wake_enabled; endproperty
  a_global_reset_n: assert property (p_global_reset_n) else $error("bit 15 not restored");
endmodule
bind power_mgmt_capability_word pm_cap_monitor mon (.clk, .nrst, .ce, .global_reset_n, .bus_reset_n, .cfg_req,
  .cfg_write, .cfg_func, .cfg_addr, .cfg_byte_en, .cfg_wdata, .cfg_ack, .cfg_hit, .cfg_rdata, .cold_wake_enabled,
  .aux_supply_flag);
`default_nettype wire

// ---- sim/cfg_host.sv ----
`default_nettype none
module cfg_host
(
  input wire logic clk, // clock
  output logic cfg_req, // request
  output logic cfg_write, // write
  output logic [2:0] cfg_func, // function
  output logic [7:0] cfg_addr, // address
  output logic [3:0] cfg_byte_en, // lanes
  output logic [31:0] cfg_wdata, // wdata
  input wire logic cfg_ack, // answer
  input wire logic cfg_hit, // claimed
  input wire logic [31:0] cfg_rdata // rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {cfg_req, cfg_write, cfg_func, cfg_addr, cfg_byte_en, cfg_wdata} = '0;
  end
  // qualifiers flip when idle so a design sampling them late sees garbage
  task automatic acc(input logic w, input logic [2:0] f, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] wd, output logic ack, output logic hit, output logic [31:0] rd);
    @(posedge clk);
    cfg_req <= 1'b1;
    {cfg_write, cfg_func, cfg_addr, cfg_byte_en, cfg_wdata} <= {w, f, a, be, wd};
    @(posedge clk);
    cfg_req <= 1'b0;
    {cfg_write, cfg_func, cfg_addr, cfg_byte_en, cfg_wdata} <= ~{w, f, a, be, wd};
    @(posedge clk);
    {ack, hit, rd} = {cfg_ack, cfg_hit, cfg_rdata};
  endtask
endmodule
`default_nettype wire

// ---- sim/power_mgmt_capability_word_tb.sv ----
`default_nettype none
module power_mgmt_capability_word_tb
  import pm_cap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] dw = {PM_CAP_DWORD, 2'b00};
  logic clk, nrst, ce, global_reset_n, bus_reset_n, cfg_req, cfg_write, cfg_ack, cfg_hit;
  logic cold_wake_enabled, aux_supply_flag;
  logic [2:0] cfg_func;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  power_mgmt_capability_word dut (.clk, .nrst, .ce, .global_reset_n, .bus_reset_n, .cfg_req, .cfg_write, .cfg_func,
    .cfg_addr, .cfg_byte_en, .cfg_wdata, .cfg_ack, .cfg_hit, .cfg_rdata, .cold_wake_enabled, .aux_supply_flag);
  cfg_host u_host (.clk, .cfg_req, .cfg_write, .cfg_func, .cfg_addr, .cfg_byte_en, .cfg_wdata, .cfg_ack, .cfg_hit,
    .cfg_rdata);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic results;
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] f, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] wd, input logic eh, input logic [31:0] er);
    logic ack, hit;
    logic [31:0] rd;
    u_host.acc(w, f, a, be, wd, ack, hit, rd);
    cmp("ack_hit", {30'h0, 1'b1, eh}, {30'h0, ack, hit});
    cmp("rdata", er, rd);
  endtask
  // a bit 15 set attempt that must not be taken: no answer, no claim, no data
  task automatic ignored;
    logic ack, hit;
    logic [31:0] rd;
    u_host.acc(1'b1, 3'h0, dw, 4'h8, '1, ack, hit, rd);
    cmp("ack_hit_off", 32'h0000_0000, {30'h0, ack, hit});
    cmp("rdata_off", 32'h0000_0000, rd);
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      miscompares++;
      results();
    end
  end
  initial
  begin
    {nrst, ce, global_reset_n, bus_reset_n} = 4'b0111;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    acc(1'b0, 3'h0, dw, 4'hC, '0, 1'b1, 32'hFE12_0000);
    acc(1'b0, 3'h0, dw, 4'h4, '0, 1'b1, 32'h0012_0000);
    acc(1'b1, 3'h0, dw, 4'hF, '0, 1'b1, '0);
    acc(1'b0, 3'h0, dw, 4'hC, '0, 1'b1, 32'h7E02_0000);
    cmp("cold_aux", '0, {30'h0, cold_wake_enabled, aux_supply_flag});
    acc(1'b1, 3'h0, dw, 4'hC, '1, 1'b1, '0);
    acc(1'b0, 3'h0, dw, 4'hC, '0, 1'b1, 32'hFE12_0000);
    acc(1'b1, 3'h0, dw, 4'h7, '0, 1'b1, '0);
    acc(1'b0, 3'h0, dw, 4'hC, '0, 1'b1, 32'hFE12_0000);
    acc(1'b0, 3'h1, dw, 4'hC, '0, 1'b0, '0);
    acc(1'b0, 3'h0, 8'hA4, 4'hC, '0, 1'b0, '0);
    acc(1'b1, 3'h0, dw, 4'h3, '0, 1'b0, '0);
    acc(1'b1, 3'h0, dw, 4'h8, '0, 1'b1, '0);
    ce <= 1'b0;
    ignored();
    ce <= 1'b1;
    bus_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    ignored();
    bus_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    acc(1'b0, 3'h0, dw, 4'hC, '0, 1'b1, 32'h7E02_0000);
    global_reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    global_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    acc(1'b0, 3'h0, dw, 4'hC, '0, 1'b1, 32'hFE12_0000);
    acc(1'b1, 3'h0, dw, 4'h8, '0, 1'b1, '0);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    acc(1'b0, 3'h0, dw, 4'hC, '0, 1'b1, 32'hFE12_0000);
    cmp("cold_aux_rst", 32'h0000_0003, {30'h0, cold_wake_enabled, aux_supply_flag});
    results();
  end
endmodule
`default_nettype wire
